// ==== tcm_pkg.sv ====
/*
  Constants and carrier types for the 8-bit timer/counter with two output
  compare channels: register byte offsets, field positions, reset values,
  waveform modes, compare output actions and clock select codes.
  Assumes a 32-bit AHB-Lite register bus, one word per register.
*/
`default_nettype none
package tcm_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_CMP_A = 8'h08;
  localparam logic [7:0] ADDR_CMP_B = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_FORCE = 8'h14;
  localparam logic [7:0] ADDR_PORT = 8'h18;
  localparam logic [7:0] ADDR_PINS = 8'h1c;

  // control register fields
  localparam int CTRL_ACT_A_LSB = 0;
  localparam int CTRL_ACT_B_LSB = 2;
  localparam int CTRL_WGM_LSB = 4;
  localparam int CTRL_CS_LSB = 8;

  // flag register bits, write one to clear
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP_LSB = 1;

  // force strobe bits, one per channel
  localparam int FORCE_LSB = 0;

  // port register: output data bits, then direction bits
  localparam int PORT_DATA_LSB = 0;
  localparam int PORT_DIR_LSB = 2;

  // pins register: output state bits, then pin level bits
  localparam int PINS_STATE_LSB = 0;
  localparam int PINS_LEVEL_LSB = 2;

  // waveform modes handled here
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_CTC = 3'h2;

  // compare output actions in non-pwm modes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // prescaler taps, as log2 of the division factor
  localparam int PRE_W = 10;
  localparam int PRE_TAP_8 = 3;
  localparam int PRE_TAP_64 = 6;
  localparam int PRE_TAP_256 = 8;
  localparam int PRE_TAP_1024 = 10;

  // reset values
  localparam logic [1:0] ACT_RST = 2'h0;
  localparam logic [2:0] WGM_RST = 3'h0;
  localparam logic [2:0] CS_RST = 3'h0;
  localparam logic [1:0] PORT_RST = 2'h0;
  localparam logic STATE_RST = 1'b0;

  typedef struct packed {
    logic [2:0] clock_select;
    logic [2:0] waveform_mode;
    logic [1:0] compare_output_action_b;
    logic [1:0] compare_output_action_a;
  } tcm_ctrl_t;

  typedef struct packed {
    logic [1:0] level;
    logic [1:0] oe;
  } tcm_pins_t;
endpackage
`default_nettype wire

// ==== tcm_timer.sv ====
/*
  8-bit timer/counter with two output compare channels, normal and
  clear-on-match counting, forced compare strobes, compare blocking after
  counter writes and port pin override, behind an AHB-Lite slave.
  Assumes a single-word AHB-Lite master, inputs synchronous to clk, and an
  interrupt controller that pulses the serviced inputs.
*/
`timescale 1ns/1ns
`default_nettype none

// Operation
// - force strobe acts like match, no flag
// - counter write blocks next tick's matches
// - output states survive waveform mode changes
// - new action applies from next match
// - reset clears both output states
// - nonzero action replaces port data on pin
// - pin override ignores waveform mode
// - action zero leaves output state alone
// - action selects set, clear or toggle
// - only waveform mode shapes counting
// - mode 0 increments and wraps ff to 00
// - normal overflow flag set on ff to 00 wrap
// - overflow flag cleared when serviced
// - mode 2 clears counter on match a
// - compare a unbuffered; low value wraps first
// - clear-on-match overflow on ff to 00
// - every match a sets flag a
// - action 1 toggles a each match
// - prescale by 1, 8, 64, 256, 1024
// - match sets compare flag on the next clock edge
// - counter write beats clear and count
// - clock select 0 stops counter and compare matches
module tcm_timer
  import tcm_pkg::*;
#(
  parameter int COUNT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // external count source
  input wire logic ext_clk_in,
  // interrupt service acknowledges
  input wire logic overflow_serviced,
  input wire logic [1:0] compare_serviced,
  // flags towards the interrupt controller
  output logic overflow_flag,
  output logic [1:0] compare_flag,
  // compare output pins
  output tcm_pins_t pins
);

  localparam int NCH = 2;
  localparam logic [COUNT_W-1:0] COUNT_MAX = '1;
  localparam logic [COUNT_W-1:0] COUNT_ONE = {{(COUNT_W-1){1'b0}}, 1'b1};

  // register address decode
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] o);
    reg_hit = (a == o);
  endfunction

  // timer clock enable from clock select
  function automatic logic sel_tick(input logic [2:0] cs,
                                    input logic [PRE_W-1:0] pre,
                                    input logic rise,
                                    input logic fall);
    case (cs)
      CS_DIV1: sel_tick = 1'b1;
      CS_DIV8: sel_tick = &pre[PRE_TAP_8-1:0];
      CS_DIV64: sel_tick = &pre[PRE_TAP_64-1:0];
      CS_DIV256: sel_tick = &pre[PRE_TAP_256-1:0];
      CS_DIV1024: sel_tick = &pre[PRE_TAP_1024-1:0];
      CS_EXT_FALL: sel_tick = fall;
      CS_EXT_RISE: sel_tick = rise;
      default: sel_tick = 1'b0;
    endcase
  endfunction

  // next output state for an action
  function automatic logic apply_action(input logic [1:0] act,
                                        input logic cur);
    case (act)
      ACT_TOGGLE: apply_action = ~cur;
      ACT_CLEAR: apply_action = 1'b0;
      ACT_SET: apply_action = 1'b1;
      default: apply_action = cur;
    endcase
  endfunction

  // ---------------- register state ----------------
  tcm_ctrl_t ctrl;
  logic [COUNT_W-1:0] counter_value;
  logic [COUNT_W-1:0] compare_value [NCH];
  logic [NCH-1:0] compare_output_state;
  logic [NCH-1:0] port_data;
  logic [NCH-1:0] port_dir;
  logic block_pending;
  logic [PRE_W-1:0] prescale;
  logic ext_level;
  logic ext_prev;

  // ---------------- bus slave ----------------
  logic wr_pend;
  logic [7:0] wr_addr;
  wire logic addr_take = hsel & htrans[1] & hready;
  wire logic [7:0] rd_addr = haddr[7:0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_take & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // data phase write strobes
  wire logic wr_ctrl = wr_pend & reg_hit(wr_addr, ADDR_CTRL);
  wire logic wr_count = wr_pend & reg_hit(wr_addr, ADDR_COUNT);
  wire logic wr_flags = wr_pend & reg_hit(wr_addr, ADDR_FLAGS);
  wire logic wr_force = wr_pend & reg_hit(wr_addr, ADDR_FORCE);
  wire logic wr_port = wr_pend & reg_hit(wr_addr, ADDR_PORT);
  wire logic [NCH-1:0] wr_cmp;
  assign wr_cmp[0] = wr_pend & reg_hit(wr_addr, ADDR_CMP_A);
  assign wr_cmp[1] = wr_pend & reg_hit(wr_addr, ADDR_CMP_B);

  // ---------------- timer clock enable ----------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prescale <= '0;
      ext_level <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      prescale <= prescale + {{(PRE_W-1){1'b0}}, 1'b1};
      ext_level <= ext_clk_in;
      ext_prev <= ext_level;
    end
  end

  wire logic ext_rise = ext_level & ~ext_prev;
  wire logic ext_fall = ~ext_level & ext_prev;
  // stopped when clock select is zero
  wire logic timer_clock_enable =
    sel_tick(ctrl.clock_select, prescale, ext_rise, ext_fall);

  // ---------------- mode decode ----------------
  wire logic mode_ctc = (ctrl.waveform_mode == WGM_CTC);
  wire logic mode_nonpwm = (ctrl.waveform_mode == WGM_NORMAL) | mode_ctc;

  // ---------------- compare channels ----------------
  wire logic [NCH-1:0] raw_match;
  wire logic [NCH-1:0] match_event;
  wire logic [NCH-1:0] force_event;
  wire logic [1:0] action [NCH];
  assign action[0] = ctrl.compare_output_action_a;
  assign action[1] = ctrl.compare_output_action_b;

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      assign raw_match[i] = (counter_value == compare_value[i]);
      // matches blocked on the tick right after a counter write
      assign match_event[i] = raw_match[i] & timer_clock_enable
                              & ~block_pending;
      assign force_event[i] = wr_force & mode_nonpwm
                              & hwdata[FORCE_LSB+i];

      // compare value written straight through, no buffer
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          compare_value[i] <= '0;
        end else if (wr_cmp[i]) begin
          compare_value[i] <= hwdata[COUNT_W-1:0];
        end
      end

      // output state: only reset, matches and strobes move it
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          compare_output_state[i] <= STATE_RST;
        end else if (match_event[i] | force_event[i]) begin
          // live action field, zero keeps the state
          compare_output_state[i] <=
            apply_action(action[i], compare_output_state[i]);
        end
      end

      // flag: hardware set beats service or software clear
      wire logic flag_clr = compare_serviced[i]
                            | (wr_flags & hwdata[FLAG_CMP_LSB+i]);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          compare_flag[i] <= 1'b0;
        end else begin
          compare_flag[i] <= match_event[i]
                             | (compare_flag[i] & ~flag_clr);
        end
      end

      // pin override depends on action field only
      wire logic drive_state = |action[i];
      wire logic next_level = drive_state ? compare_output_state[i]
                                          : port_data[i];
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pins.level[i] <= 1'b0;
          pins.oe[i] <= 1'b0;
        end else begin
          pins.level[i] <= next_level;
          pins.oe[i] <= port_dir[i];
        end
      end
    end
  endgenerate

  // ---------------- counter ----------------
  wire logic ctc_clear = mode_ctc & match_event[0];
  // ff to 00 is an overflow whether by wrap or by clear at top
  wire logic count_wrap = timer_clock_enable
                          & (counter_value == COUNT_MAX);
  wire logic [COUNT_W-1:0] next_count =
    wr_count ? hwdata[COUNT_W-1:0] :
    ~timer_clock_enable ? counter_value :
    ctc_clear ? '0 :
    counter_value + COUNT_ONE;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_value <= '0;
    end else begin
      counter_value <= next_count;
    end
  end

  // block holds until the next timer clock tick consumes it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      block_pending <= 1'b0;
    end else if (wr_count) begin
      block_pending <= 1'b1;
    end else if (timer_clock_enable) begin
      block_pending <= 1'b0;
    end
  end

  // overflow when the count rolls from max to zero
  wire logic ovf_clr = overflow_serviced
                       | (wr_flags & hwdata[FLAG_OVF]);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= (count_wrap & ~wr_count)
                       | (overflow_flag & ~ovf_clr);
    end
  end

  // ---------------- software registers ----------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl.compare_output_action_a <= ACT_RST;
      ctrl.compare_output_action_b <= ACT_RST;
      ctrl.waveform_mode <= WGM_RST;
      ctrl.clock_select <= CS_RST;
    end else if (wr_ctrl) begin
      // output states are left untouched by mode changes
      ctrl.compare_output_action_a <= hwdata[CTRL_ACT_A_LSB+:2];
      ctrl.compare_output_action_b <= hwdata[CTRL_ACT_B_LSB+:2];
      ctrl.waveform_mode <= hwdata[CTRL_WGM_LSB+:3];
      ctrl.clock_select <= hwdata[CTRL_CS_LSB+:3];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_data <= PORT_RST;
      port_dir <= PORT_RST;
    end else if (wr_port) begin
      port_data <= hwdata[PORT_DATA_LSB+:NCH];
      port_dir <= hwdata[PORT_DIR_LSB+:NCH];
    end
  end

  // ---------------- read path ----------------
  wire logic [31:0] rd_ctrl = 32'(ctrl.compare_output_action_a)
    << CTRL_ACT_A_LSB
    | 32'(ctrl.compare_output_action_b) << CTRL_ACT_B_LSB
    | 32'(ctrl.waveform_mode) << CTRL_WGM_LSB
    | 32'(ctrl.clock_select) << CTRL_CS_LSB;
  wire logic [31:0] rd_flags = 32'(overflow_flag) << FLAG_OVF
    | 32'(compare_flag) << FLAG_CMP_LSB;
  wire logic [31:0] rd_port = 32'(port_data) << PORT_DATA_LSB
    | 32'(port_dir) << PORT_DIR_LSB;
  wire logic [31:0] rd_pins = 32'(compare_output_state) << PINS_STATE_LSB
    | 32'(pins.level) << PINS_LEVEL_LSB;

  // unmapped and force register read as zero
  wire logic [31:0] rd_word =
    reg_hit(rd_addr, ADDR_CTRL) ? rd_ctrl :
    reg_hit(rd_addr, ADDR_COUNT) ? 32'(counter_value) :
    reg_hit(rd_addr, ADDR_CMP_A) ? 32'(compare_value[0]) :
    reg_hit(rd_addr, ADDR_CMP_B) ? 32'(compare_value[1]) :
    reg_hit(rd_addr, ADDR_FLAGS) ? rd_flags :
    reg_hit(rd_addr, ADDR_PORT) ? rd_port :
    reg_hit(rd_addr, ADDR_PINS) ? rd_pins :
    32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (addr_take & ~hwrite) begin
        hrdata <= rd_word;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== tcm_timer_assertions.sv ====
/*
  Concurrent checks on the timer's ports: bus answer, flag clearing,
  pin enable changes and read data holding.
  Assumes tcm_timer and tcm_pkg; bound to every instance of the timer.
*/
`timescale 1ns/1ns
`default_nettype none
module tcm_timer_checker
  import tcm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // flags and pins
  input wire logic overflow_serviced,
  input wire logic [1:0] compare_serviced,
  input wire logic overflow_flag,
  input wire logic [1:0] compare_flag,
  input wire tcm_pins_t pins
);
  wire logic take = hsel && htrans[1] && hready;
  wire logic rd = take && !hwrite;
  logic fl_wr;
  logic pt_wr;
  // data phase of flag and port writes
  always_ff @(posedge clk) begin
    fl_wr <= take && hwrite && haddr[7:0] == ADDR_FLAGS;
    pt_wr <= take && hwrite && haddr[7:0] == ADDR_PORT;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_reset_clear: assert property ($rose(rst_n) |->
    pins == 4'h0 && !overflow_flag && compare_flag == 2'h0)
    else $error("state not cleared by reset");
  a_ovf_fall: assert property ($fell(overflow_flag) |->
    $past(overflow_serviced) || $past(fl_wr))
    else $error("overflow flag cleared without cause");
  a_cmpa_fall: assert property ($fell(compare_flag[0]) |->
    $past(compare_serviced[0]) || $past(fl_wr))
    else $error("flag a cleared without cause");
  a_cmpb_fall: assert property ($fell(compare_flag[1]) |->
    $past(compare_serviced[1]) || $past(fl_wr))
    else $error("flag b cleared without cause");
  a_oe_change: assert property ($changed(pins.oe) |->
    $past(pt_wr) || $past(pt_wr, 2))
    else $error("pin enable changed without port write");
  a_rdata_stand: assert property ($changed(hrdata) |-> $past(rd))
    else $error("read data changed without read");
  c_ovf: cover property ($rose(overflow_flag));
  c_cmp: cover property ($rose(compare_flag[0]));
  c_tog: cover property ($changed(pins.level[0]));
endmodule
bind tcm_timer tcm_timer_checker chk (.clk, .rst_n, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .overflow_serviced, .compare_serviced, .overflow_flag, .compare_flag,
  .pins);
`default_nettype wire

// ==== tcm_timer_test.sv ====
/*
  Self-checking bench for tcm_timer: reset values, forced actions, pin
  override, match blocking, overflow, clear-on-match toggling, prescale.
  Assumes tcm_pkg and the checker file compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
module tcm_timer_test
  import tcm_pkg::*;
;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, overflow_serviced = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0] htrans = '0, compare_serviced = '0, compare_flag, st, p, a;
  logic hreadyout, hresp, overflow_flag, old;
  wire logic hready;
  tcm_pins_t pins;
  logic [7:0] c;
  logic [1:0] acts [6] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h3};
  logic [7:0] regs [4] = '{ADDR_CTRL, ADDR_FLAGS, ADDR_PINS, 8'h20};
  int n_errors = 0, num_checks = 0, i, k;
  int div [5] = '{1, 8, 64, 256, 1024};
  logic ext = 1'b0;
  assign hready = hreadyout;
  tcm_timer dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .ext_clk_in(ext), .overflow_serviced, .compare_serviced,
    .overflow_flag, .compare_flag, .pins);
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic stop_test;
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic lim(input int n);
    if (n >= 40) begin
      n_errors++;
      stop_test;
    end
  endtask
  // one edge, then until hready is seen high
  task automatic rdy;
    int j;
    j = 0;
    do begin
      @(posedge clk);
      j++;
    end while (hready !== 1'b1 && j < 40);
    lim(j);
  endtask
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, ad};
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  function automatic logic [31:0] ctrl(input logic [2:0] cs,
      input logic [2:0] m, input logic [1:0] ac);
    return {21'h0, cs, 1'b0, m, ac, ac};
  endfunction
  function automatic logic nxt(input logic [1:0] ac, input logic s);
    case (ac)
      ACT_TOGGLE: return ~s;
      ACT_CLEAR: return 1'b0;
      ACT_SET: return 1'b1;
      default: return s;
    endcase
  endfunction
  initial begin
    #(8 * 60000);
    n_errors++;
    stop_test;
  end
  initial begin
    void'($urandom(19));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      bus(1'b0, regs[i], 0);
      chk(r, 0);
    end
    p = 2'($urandom);
    st = 2'h0;
    bus(1'b1, ADDR_PORT, {28'h0, 2'b11, p});
    for (i = 0; i < 6; i++) begin
      a = acts[i];
      // odd passes in clear-on-match mode, state must carry over
      bus(1'b1, ADDR_CTRL, ctrl(CS_STOP, i[0] ? WGM_CTC : WGM_NORMAL, a));
      bus(1'b1, ADDR_FORCE, 32'h3);
      st = {nxt(a, st[1]), nxt(a, st[0])};
      @(posedge clk);
      bus(1'b0, ADDR_PINS, 0);
      chk(r, {28'h0, (a != 0) ? st : p, st});
      chk(pins, {(a != 0) ? st : p, 2'b11});
    end
    bus(1'b0, ADDR_FLAGS, 0);
    chk(r, 0);
    c = 8'($urandom_range(16, 200));
    bus(1'b1, ADDR_CTRL, ctrl(CS_STOP, WGM_NORMAL, ACT_NONE));
    bus(1'b1, ADDR_CMP_A, {24'h0, c});
    bus(1'b1, ADDR_COUNT, {24'h0, c});
    bus(1'b0, ADDR_COUNT, 0);
    chk(r, {24'h0, c});
    bus(1'b1, ADDR_CTRL, ctrl(CS_DIV1, WGM_NORMAL, ACT_NONE));
    bus(1'b1, ADDR_CTRL, ctrl(CS_STOP, WGM_NORMAL, ACT_NONE));
    chk(compare_flag[0], 0);
    bus(1'b1, ADDR_COUNT, {24'h0, c - 8'h3});
    bus(1'b1, ADDR_CTRL, ctrl(CS_DIV1, WGM_NORMAL, ACT_NONE));
    for (k = 0; k < 40 && compare_flag[0] !== 1'b1; k++) @(posedge clk);
    lim(k);
    bus(1'b1, ADDR_COUNT, 32'hfd);
    for (k = 0; k < 40 && overflow_flag !== 1'b1; k++) @(posedge clk);
    lim(k);
    bus(1'b1, ADDR_CTRL, ctrl(CS_STOP, WGM_NORMAL, ACT_NONE));
    bus(1'b0, ADDR_COUNT, 0);
    chk(r < 32'h10, 1);
    chk(compare_flag, 2'b11);
    overflow_serviced <= 1'b1;
    compare_serviced <= 2'b11;
    @(posedge clk);
    overflow_serviced <= 1'b0;
    compare_serviced <= 2'b00;
    @(posedge clk);
    chk({overflow_flag, compare_flag}, 0);
    c = 8'($urandom_range(2, 9));
    bus(1'b1, ADDR_CMP_A, {24'h0, c});
    bus(1'b1, ADDR_COUNT, 32'hf8);
    bus(1'b1, ADDR_CTRL, ctrl(CS_DIV1, WGM_CTC, ACT_TOGGLE));
    for (k = 0; k < 40 && overflow_flag !== 1'b1; k++) @(posedge clk);
    lim(k);
    bus(1'b1, ADDR_FLAGS, 32'h7);
    old = pins.level[0];
    for (k = 0; k < 40 && pins.level[0] === old; k++) @(posedge clk);
    lim(k);
    old = pins.level[0];
    for (k = 0; k < 40 && pins.level[0] === old; k++) @(posedge clk);
    chk(k, c + 1);
    chk({overflow_flag, compare_flag[0]}, 2'b01);
    bus(1'b1, ADDR_CTRL, ctrl(CS_STOP, WGM_CTC, ACT_TOGGLE));
    bus(1'b0, ADDR_COUNT, 0);
    chk(r <= {24'h0, c}, 1);
    for (i = 0; i < 5; i++) begin
      bus(1'b1, ADDR_COUNT, 0);
      bus(1'b1, ADDR_CTRL, ctrl(CS_DIV1 + 3'(i), WGM_NORMAL, ACT_NONE));
      repeat (16 * div[i]) @(posedge clk);
      bus(1'b1, ADDR_CTRL, ctrl(CS_STOP, WGM_NORMAL, ACT_NONE));
      bus(1'b0, ADDR_COUNT, 0);
      chk(r >= 32'd16 && r <= 32'd18, 1);
    end
    // external rising edges are the only ticks
    k = $urandom_range(3, 12);
    bus(1'b1, ADDR_COUNT, 0);
    bus(1'b1, ADDR_CTRL, ctrl(CS_EXT_RISE, WGM_NORMAL, ACT_NONE));
    repeat (k) begin
      ext <= 1'b1;
      repeat (2) @(posedge clk);
      ext <= 1'b0;
      repeat (2) @(posedge clk);
    end
    bus(1'b1, ADDR_CTRL, ctrl(CS_STOP, WGM_NORMAL, ACT_NONE));
    bus(1'b0, ADDR_COUNT, 0);
    chk(r, k);
    stop_test;
  end
endmodule
`default_nettype wire
